// ### channel_b_pkg.sv
package channel_b_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_OUTPUT_SETTINGS = 14'h043b;
    localparam logic [13:0] IDX_RATIO_LOW = 14'h043c;
    localparam logic [13:0] IDX_RATIO_HIGH = 14'h043d;
    localparam logic [13:0] IDX_START_PHASE = 14'h043e;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int RATIO_W = 10;
    localparam int PHASE_W = 6;
    localparam int MODE_W = 2;
    localparam int INVERT_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int RATIO_HIGH_W = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OUTPUT_SETTINGS = 8'h00;
    localparam logic [7:0] RST_RATIO_LOW = 8'h00;
    localparam logic [1:0] RST_RATIO_HIGH = 2'h0;
    localparam logic [5:0] RST_START_PHASE = 6'h00;

    // ------------------------------------------------------------
    // Driver modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRIVE_14MA = 2'h0,
        DRIVE_21MA = 2'h1,
        DRIVE_28MA = 2'h2,
        DRIVE_OFF = 2'h3
    } drive_mode_e;

    // Channel output settings as one carrier
    typedef struct packed {
        drive_mode_e mode;
        logic invert;
    } out_settings_s;

    // Divider programming as one carrier
    typedef struct packed {
        logic [RATIO_W-1:0] ratio;
        logic [PHASE_W-1:0] phase;
    } div_cfg_s;

    // Sync state of the divider
    typedef enum logic {
        SYNC_STATIC = 1'b0,
        SYNC_RUN = 1'b1
    } sync_state_e;

endpackage : channel_b_pkg

// ### channel_b_divider_core.sv
`timescale 1ns/10ps
module channel_b_divider_core (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_half_tick,
    input wire logic i_load,
    input wire logic i_run,
    input wire channel_b_pkg::div_cfg_s i_cfg,
    output logic o_level
);

    // ------------------------------------------------------------
    // Half-period counter
    // ------------------------------------------------------------
    // Counts half periods of the prescaler clock; a full output period
    // is 2*(ratio+1) half steps, high for the first ratio+1 of them.
    logic [10:0] cnt_r;
    logic [9:0] ratio_r;
    logic [10:0] last_step;
    logic [11:0] period;
    logic [10:0] phase_start;

    assign last_step = {ratio_r, 1'b1};
    // Twelve bits: divide-by-1024 needs 2048 half steps, which wraps 11 bits
    assign period = {1'b0, i_cfg.ratio, 1'b0} + 12'h002;
    // Phase wraps inside one output period for small ratios
    assign phase_start = 11'(({6'h00, i_cfg.phase}) % period);

    // Ratio is captured only at a load so a live write cannot glitch
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ratio_r <= 10'h000;
        end else if (i_load) begin
            ratio_r <= i_cfg.ratio;
        end
    end

    // Restart at the phase offset, then step each half period
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= 11'h000;
        end else if (i_load) begin
            cnt_r <= phase_start;
        end else if (i_run && i_half_tick) begin
            cnt_r <= (cnt_r == last_step) ? 11'h000 : cnt_r + 11'h001;
        end
    end

    // Output level; held low while i_run is low (static sync state without the mask)
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_level <= 1'b0;
        end else if (!i_run) begin
            o_level <= 1'b0;
        end else begin
            o_level <= (cnt_r <= {1'b0, ratio_r});
        end
    end

endmodule : channel_b_divider_core

// ### channel_b_output.sv
`timescale 1ns/10ps
module channel_b_output (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_prescaler_half_tick,
    input wire logic i_sync_event,
    input wire logic i_sync_mask,
    output logic o_clk_out,
    output logic o_clk_out_oe,
    output logic [1:0] o_drive_mode,
    output logic o_driver_power_down,
    output logic o_divider_running
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    channel_b_pkg::out_settings_s settings_r;
    logic [7:0] ratio_low_r;
    logic [1:0] ratio_high_r;
    logic [5:0] phase_r;

    logic [13:0] index;
    logic aligned;
    logic hit_settings;
    logic hit_low;
    logic hit_high;
    logic hit_phase;
    logic mapped;
    logic access;
    logic wr_en;

    assign index = i_paddr[15:2];
    assign aligned = (i_paddr[1:0] == 2'h0);
    assign hit_settings = aligned && (index == channel_b_pkg::IDX_OUTPUT_SETTINGS);
    assign hit_low = aligned && (index == channel_b_pkg::IDX_RATIO_LOW);
    assign hit_high = aligned && (index == channel_b_pkg::IDX_RATIO_HIGH);
    assign hit_phase = aligned && (index == channel_b_pkg::IDX_START_PHASE);
    assign mapped = hit_settings | hit_low | hit_high | hit_phase;
    // One wait state: the answer comes on the second access cycle
    assign access = i_psel && i_penable && !o_pready;
    assign wr_en = access && i_pwrite;

    // Output settings register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            settings_r <= channel_b_pkg::out_settings_s'(
                channel_b_pkg::RST_OUTPUT_SETTINGS[2:0]);
        end else if (wr_en && hit_settings) begin
            settings_r.invert <= i_pwdata[channel_b_pkg::INVERT_BIT];
            settings_r.mode <= channel_b_pkg::drive_mode_e'(
                i_pwdata[channel_b_pkg::MODE_LSB +: channel_b_pkg::MODE_W]);
        end
    end

    // Ratio low byte
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ratio_low_r <= channel_b_pkg::RST_RATIO_LOW;
        end else if (wr_en && hit_low) begin
            ratio_low_r <= i_pwdata[7:0];
        end
    end

    // Ratio top bits
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ratio_high_r <= channel_b_pkg::RST_RATIO_HIGH;
        end else if (wr_en && hit_high) begin
            ratio_high_r <= i_pwdata[channel_b_pkg::RATIO_HIGH_W-1:0];
        end
    end

    // Start phase
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_r <= channel_b_pkg::RST_START_PHASE;
        end else if (wr_en && hit_phase) begin
            phase_r <= i_pwdata[channel_b_pkg::PHASE_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // Reserved bits read as zero
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_settings) begin
            rd_nxt[2:0] = settings_r;
        end else if (hit_low) begin
            rd_nxt[7:0] = ratio_low_r;
        end else if (hit_high) begin
            rd_nxt[1:0] = ratio_high_r;
        end else if (hit_phase) begin
            rd_nxt[5:0] = phase_r;
        end
    end

    // Ready, read data and error for one cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= access;
            o_prdata <= (access && !i_pwrite) ? rd_nxt : 32'h0000_0000;
            o_pslverr <= access && !mapped;
        end
    end

    // ------------------------------------------------------------
    // Sync control
    // ------------------------------------------------------------
    channel_b_pkg::sync_state_e state_r;
    channel_b_pkg::sync_state_e state_nxt;
    logic accept_sync;
    logic load;
    logic run;

    // A masked channel never sees a sync event
    assign accept_sync = i_sync_event && !i_sync_mask;

    always_comb begin
        case (state_r)
            channel_b_pkg::SYNC_STATIC: begin
                state_nxt = (accept_sync || i_sync_mask) ?
                    channel_b_pkg::SYNC_RUN : channel_b_pkg::SYNC_STATIC;
            end
            channel_b_pkg::SYNC_RUN: begin
                state_nxt = channel_b_pkg::SYNC_RUN;
            end
            default: begin
                state_nxt = channel_b_pkg::SYNC_STATIC;
            end
        endcase
    end

    // Static after reset until the first sync or the mask
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= channel_b_pkg::SYNC_STATIC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Mask releases without waiting for a registered state: the load
    // and run terms see it in the same cycle
    assign load = accept_sync ||
        (state_r == channel_b_pkg::SYNC_STATIC && i_sync_mask);
    assign run = (state_r == channel_b_pkg::SYNC_RUN) || i_sync_mask;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    channel_b_pkg::div_cfg_s cfg;
    logic level;

    assign cfg.ratio = {ratio_high_r, ratio_low_r};
    assign cfg.phase = phase_r;

    channel_b_divider_core u_core (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_half_tick(i_prescaler_half_tick),
        .i_load(load),
        .i_run(run),
        .i_cfg(cfg),
        .o_level(level)
    );

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic power_down;

    assign power_down = (settings_r.mode == channel_b_pkg::DRIVE_OFF);

    // Powered-down driver is held quiet as well as released
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_clk_out <= 1'b0;
            o_clk_out_oe <= 1'b0;
            o_drive_mode <= 2'h0;
            o_driver_power_down <= 1'b0;
            o_divider_running <= 1'b0;
        end else begin
            o_clk_out <= power_down ? 1'b0 : (level ^ settings_r.invert);
            o_clk_out_oe <= !power_down;
            o_drive_mode <= settings_r.mode;
            o_driver_power_down <= power_down;
            o_divider_running <= run;
        end
    end

endmodule : channel_b_output

// ### channel_b_output_assertions.sv
`timescale 1ns/10ps
module channel_b_output_assertions (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_prescaler_half_tick,
    input wire logic i_sync_event,
    input wire logic i_sync_mask,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_clk_out,
    input wire logic o_clk_out_oe,
    input wire logic [1:0] o_drive_mode,
    input wire logic o_driver_power_down,
    input wire logic o_divider_running
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Enable lags reset release by one edge, hence the guard
    oe_follows_mode_a: assert property ($past(!i_sys_rst)
        |-> o_clk_out_oe == (o_drive_mode != 2'h3))
        else $error("output enable disagrees with mode");
    power_down_a: assert property (
        o_driver_power_down == (o_drive_mode == 2'h3))
        else $error("power down disagrees with mode");
    off_quiet_a: assert property (o_driver_power_down |-> !o_clk_out)
        else $error("clock toggles while powered down");
    // Static level may be inverted, so only a register write may move it
    static_low_a: assert property (
        !o_divider_running && !i_psel |=> $stable(o_clk_out))
        else $error("clock moved while divider static");
    mask_release_a: assert property (
        i_sync_mask |-> ##[0:2] o_divider_running)
        else $error("mask did not release divider");
    sync_start_a: assert property (
        i_sync_event && !i_sync_mask |-> ##[1:2] o_divider_running)
        else $error("sync did not start divider");
    // Only half ticks, syncs, mask changes and register writes may move the output, so quiet input means steady clock
    tick_timed_a: assert property (
        (!i_prescaler_half_tick && !i_sync_event && !i_psel
        && $stable(i_sync_mask))[*3] |=> $stable(o_clk_out))
        else $error("clock moved without a half tick");
    apb_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("no ready after access");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside ready cycle");

    cover property (o_pslverr);
    cover property (o_driver_power_down);
    cover property ($rose(o_divider_running));
endmodule : channel_b_output_assertions

// ### channel_b_output_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module channel_b_output_tb_top;
    logic i_clk = 0, i_sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, tick = 0, sync = 0, mask = 0;
    logic clk_out, oe, pd, running;
    logic [1:0] mode;
    int errors = 0, checks = 0, pos, m;

    channel_b_output i_channel_b_output (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_prescaler_half_tick(tick), .i_sync_event(sync), .i_sync_mask(mask),
        .o_clk_out(clk_out), .o_clk_out_oe(oe), .o_drive_mode(mode),
        .o_driver_power_down(pd), .o_divider_running(running));

    // 200 MHz system clock
    always #2.5 i_clk = ~i_clk;

    task tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // APB master: request held until ready is sampled high
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge i_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1;
        n = 0;
        do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin errors++; tally_and_finish(); end
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(0, a, 0, q, e);
        `CHK(q, x)
        `CHK(e, xe)
    endtask : rd

    // ------------------------------------------------------------
    // Divider stimulus, one spaced half tick per step
    // ------------------------------------------------------------
    task automatic cfg(input int r, input int p, input logic inv);
        wr(16'h10f0, 32'(r % 256));
        wr(16'h10f4, 32'(r / 256));
        wr(16'h10f8, 32'(p));
        wr(16'h10ec, {31'h0, inv});
    endtask : cfg

    task automatic pulse_sync;
        @(posedge i_clk) sync <= 1;
        @(posedge i_clk) sync <= 0;
        repeat (2) @(posedge i_clk);
    endtask : pulse_sync

    // Expected count kept in pos; high half while count below ratio plus one
    task automatic steps(input int r, input logic inv, input int n);
        repeat (n) begin
            #1 `CHK(clk_out, (pos < r + 1) ^ inv)
            @(posedge i_clk) tick <= 1;
            @(posedge i_clk) tick <= 0;
            // Output shows a new count two edges after the tick is taken
            repeat (2) @(posedge i_clk);
            pos = (pos + 1) % (2 * (r + 1));
        end
    endtask : steps

    // Watchdog against a hung sequence; the apb task ends a hung handshake itself after 20 cycles
    initial begin
        repeat (100000) @(posedge i_clk);
        errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 0;
        rd(16'h10ec, 32'h0, 0);
        rd(16'h10f0, 32'h0, 0);
        rd(16'h10f8, 32'h0, 0);
        rd(16'h1100, 32'h0, 1);
        rd(16'h10ed, 32'h0, 1);
        wr(16'h10f0, 32'hffffffff);
        rd(16'h10f0, 32'hff, 0);
        wr(16'h10f4, 32'hffffffff);
        rd(16'h10f4, 32'h3, 0);
        wr(16'h10f8, 32'hffffffff);
        rd(16'h10f8, 32'h3f, 0);
        for (m = 0; m < 4; m++) begin
            wr(16'h10ec, 32'(m * 2) | 32'hf8);
            rd(16'h10ec, 32'(m * 2), 0);
            `CHK(mode, 2'(m))
            `CHK(pd, m == 3)
            `CHK(oe, m != 3)
        end
        cfg(0, 0, 0);
        pulse_sync();
        pos = 0;
        steps(0, 0, 4);
        cfg(1, 1, 0);
        pulse_sync();
        pos = 1;
        steps(1, 0, 6);
        cfg(5, 63, 1);
        pulse_sync();
        pos = 63 % 12;
        steps(5, 1, 14);
        // New ratio waits for the next sync
        wr(16'h10f0, 32'h2);
        steps(5, 1, 4);
        @(posedge i_clk) mask <= 1;
        pulse_sync();
        steps(5, 1, 4);
        @(posedge i_clk) mask <= 0;
        pulse_sync();
        // Phase 63 still stands, wrapped into the new six-step period
        pos = 63 % 6;
        steps(2, 1, 8);
        // Second reset, then mask alone must free the static divider
        @(posedge i_clk) i_sys_rst <= 1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 0;
        repeat (2) @(posedge i_clk);
        `CHK(running, 1'b0)
        mask <= 1;
        repeat (3) @(posedge i_clk);
        `CHK(running, 1'b1)
        tally_and_finish();
    end
endmodule : channel_b_output_tb_top

bind channel_b_output channel_b_output_assertions i_channel_b_output_assertions (.*);
